// file: hw/dcc_crc_unit.sv
// crc-32 generator for one dma channel with apb register slots
// assumes the channel datapath gives one-cycle strobes for start, byte, done, abort
//
// Contract
// - any write to crc value loads the generator with the written word
// - reads of crc value return the generator bit-reversed and inverted
// - the generator keeps accumulating across transactions until crc value is written
// - post-transfer-done flag clears when a channel transaction begins
// - with post enable, a successful crc write-out sets the done flag
// - abort by firmware or target suppresses the write-out; flag stays zero
// - status bits 3,1,0 are test bits, 31:4 reserved, test slot reserved
// - calc enable bit gates whether transferred data updates the generator
// - post enable writes the crc out after completion, never after an abort
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcc_crc_unit (
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        XFER_START,
    input  wire logic        XFER_BYTE_VALID,
    input  wire logic [7:0]  XFER_BYTE,
    input  wire logic        XFER_DONE,
    input  wire logic        XFER_ABORT,
    output logic             CRC_OUT_VALID,
    output logic      [31:0] CRC_OUT_DATA,
    input  wire logic        CRC_OUT_ACK
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_POST} dcc_state_t;
    dcc_state_t  state_q, state_d;
    logic [31:0] crc_q, crc_d;
    logic        done_q, done_d;
    logic        calc_en_q, calc_en_d;
    logic        post_en_q, post_en_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        ovalid_q, ovalid_d;
    logic [31:0] odata_q, odata_d;
    logic        wr_acc;
    logic        rd_acc;
    logic [31:0] crc_step;
    logic [31:0] crc_view;
    logic [31:0] crc_rev;
    logic [31:0] crc_fold;
    logic [31:0] fold_rev;
    logic        bus_acc;

    // the answer is built in the first access cycle; a write lands only at the edge
    // where the master samples pready high, so a dropped request never changes state
    assign bus_acc = PSEL && PENABLE && !pready_q;
    assign wr_acc  = PSEL && PENABLE && PWRITE && pready_q;
    assign rd_acc  = bus_acc && !PWRITE;

    // ************************************************************
    // crc arithmetic
    // ************************************************************
    // msb-first register fed lsb first; reversing and inverting it on the way out
    // gives the usual crc-32 result, and a written word is the generator itself
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < dcc_pkg::BYTE_BITS; i++) begin
            if (r[31] ^ b[i]) begin
                r = {r[30:0], 1'b0} ^ dcc_pkg::CRC_POLY;
            end else begin
                r = {r[30:0], 1'b0};
            end
        end
        return r;
    endfunction

    // view of the register that software reads; the write-out takes the folded value below
    assign crc_step = crc_byte(crc_q, XFER_BYTE);
    // value after this cycle's byte, before any bus write; feeds the write-out word
    assign crc_fold = (state_q == ST_BUSY && XFER_BYTE_VALID && calc_en_q) ? crc_step : crc_q;
    assign crc_view = ~crc_rev;

    // ************************************************************
    // bit reversal
    // ************************************************************
    // wiring only; the write-out reverses the folded value so that a byte landing
    // in the same cycle as done is not lost from the offered word
    for (genvar g = 0; g < $bits(crc_q); g++) begin : g_rev
        assign crc_rev[g]  = crc_q[$bits(crc_q) - 1 - g];
        assign fold_rev[g] = crc_fold[$bits(crc_q) - 1 - g];
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        state_d   = state_q;
        crc_d     = crc_q;
        done_d    = done_q;
        calc_en_d = calc_en_q;
        post_en_d = post_en_q;
        ovalid_d  = ovalid_q;
        odata_d   = odata_q;
        // datapath updates; a bus write below wins over a byte in the same cycle
        unique case (state_q)
            ST_IDLE: begin
                if (XFER_START) begin
                    state_d = ST_BUSY;
                    done_d  = 1'b0;
                end
            end
            ST_BUSY: begin
                if (XFER_BYTE_VALID && calc_en_q) begin
                    crc_d = crc_step;
                end
                if (XFER_ABORT) begin
                    state_d = ST_IDLE;
                end else if (XFER_DONE) begin
                    if (post_en_q) begin
                        state_d  = ST_POST;
                        ovalid_d = 1'b1;
                        odata_d  = ~fold_rev;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_POST: begin
                if (XFER_ABORT) begin
                    // the target ended things before taking the word
                    state_d  = ST_IDLE;
                    ovalid_d = 1'b0;
                end else if (CRC_OUT_ACK) begin
                    state_d  = ST_IDLE;
                    ovalid_d = 1'b0;
                    done_d   = 1'b1;
                end
            end
        endcase
        // register writes
        if (wr_acc && PADDR == dcc_pkg::ADDR_CRC_VALUE) begin
            crc_d = PWDATA;
        end
        if (wr_acc && PADDR == dcc_pkg::ADDR_CONTROL) begin
            calc_en_d = PWDATA[dcc_pkg::CTRL_CALC_BIT];
            post_en_d = PWDATA[dcc_pkg::CTRL_POST_BIT];
        end
    end

    // ************************************************************
    // apb answer
    // ************************************************************
    // reserved and test bits read as zero; unmapped addresses answer with slverr
    always_comb begin
        prdata_d  = dcc_pkg::ZERO_WORD;
        pready_d  = PSEL && PENABLE && !pready_q;
        pslverr_d = 1'b0;
        if (bus_acc) begin
            unique case (PADDR)
                dcc_pkg::ADDR_CRC_VALUE: begin
                    if (rd_acc) begin
                        prdata_d = crc_view;
                    end
                end
                dcc_pkg::ADDR_OUT_STATUS: begin
                    if (rd_acc) begin
                        prdata_d[dcc_pkg::STAT_DONE_BIT] = done_q;
                    end
                end
                dcc_pkg::ADDR_TEST_SLOT: begin
                    prdata_d = dcc_pkg::ZERO_WORD;
                end
                dcc_pkg::ADDR_CONTROL: begin
                    if (rd_acc) begin
                        prdata_d[dcc_pkg::CTRL_CALC_BIT] = calc_en_q;
                        prdata_d[dcc_pkg::CTRL_POST_BIT] = post_en_q;
                    end
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_q   <= ST_IDLE;
            crc_q     <= dcc_pkg::CRC_VALUE_RESET;
            done_q    <= 1'b0;
            calc_en_q <= 1'b0;
            post_en_q <= 1'b0;
            prdata_q  <= dcc_pkg::ZERO_WORD;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            ovalid_q  <= 1'b0;
            odata_q   <= dcc_pkg::ZERO_WORD;
        end else begin
            state_q   <= state_d;
            crc_q     <= crc_d;
            done_q    <= done_d;
            calc_en_q <= calc_en_d;
            post_en_q <= post_en_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            ovalid_q  <= ovalid_d;
            odata_q   <= odata_d;
        end
    end

    assign PRDATA        = prdata_q;
    assign PREADY        = pready_q;
    assign PSLVERR       = pslverr_q;
    assign CRC_OUT_VALID = ovalid_q;
    assign CRC_OUT_DATA  = odata_q;

    // ************************************************************
    // checks
    // ************************************************************
    property p_load;
        @(posedge CLOCK) disable iff (SRST)
        wr_acc && PADDR == dcc_pkg::ADDR_CRC_VALUE |=> crc_q == $past(PWDATA);
    endproperty
    a_load: assert property (p_load) else $error("crc write did not load");

    property p_read;
        @(posedge CLOCK) disable iff (SRST)
        rd_acc && PADDR == dcc_pkg::ADDR_CRC_VALUE |=>
            PRDATA[31] == !$past(crc_q[0]) && PRDATA[0] == !$past(crc_q[31]) && PREADY;
    endproperty
    a_read: assert property (p_read) else $error("crc read wrong");

    property p_hold;
        @(posedge CLOCK) disable iff (SRST)
        !wr_acc && !(state_q == ST_BUSY && XFER_BYTE_VALID && calc_en_q) |=> $stable(crc_q);
    endproperty
    a_hold: assert property (p_hold) else $error("crc changed without cause");

    property p_clear;
        @(posedge CLOCK) disable iff (SRST)
        state_q == ST_IDLE && XFER_START |=> !done_q && state_q == ST_BUSY;
    endproperty
    a_clear: assert property (p_clear) else $error("done not cleared at start");

    property p_set;
        @(posedge CLOCK) disable iff (SRST)
        state_q == ST_POST && CRC_OUT_ACK && !XFER_ABORT |=> done_q && !CRC_OUT_VALID;
    endproperty
    a_set: assert property (p_set) else $error("done not set after write-out");

    property p_abort;
        @(posedge CLOCK) disable iff (SRST)
        state_q != ST_IDLE && XFER_ABORT |=> !done_q && !CRC_OUT_VALID;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not suppress write-out");

    property p_status;
        @(posedge CLOCK) disable iff (SRST)
        rd_acc && PADDR == dcc_pkg::ADDR_OUT_STATUS |=> PRDATA[31:3] == 29'h0 && PRDATA[1:0] == 2'h0;
    endproperty
    a_status: assert property (p_status) else $error("reserved status bits set");

    property p_gate;
        @(posedge CLOCK) disable iff (SRST)
        !calc_en_q && !wr_acc |=> $stable(crc_q);
    endproperty
    a_gate: assert property (p_gate) else $error("crc ran while disabled");

    property p_post;
        @(posedge CLOCK) disable iff (SRST)
        state_q == ST_BUSY && XFER_DONE && !XFER_ABORT && post_en_q |=> CRC_OUT_VALID;
    endproperty
    a_post: assert property (p_post) else $error("write-out not offered");

    property p_step;
        @(posedge CLOCK) disable iff (SRST)
        state_q == ST_BUSY && XFER_BYTE_VALID && calc_en_q && !wr_acc |=> crc_q == $past(crc_step);
    endproperty
    a_step: assert property (p_step) else $error("crc byte update wrong");

    // the answer is a single-cycle pulse, so a back-to-back master never sees it twice
    property p_ready_pulse;
        @(posedge CLOCK) disable iff (SRST)
        PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");

    property p_ro_status;
        @(posedge CLOCK) disable iff (SRST)
        wr_acc && PADDR == dcc_pkg::ADDR_OUT_STATUS && state_q == ST_IDLE |=> $stable(done_q);
    endproperty
    a_ro_status: assert property (p_ro_status) else $error("status slot took a write");

    // the offered word must not move while the datapath is still deciding to take it
    property p_offer_hold;
        @(posedge CLOCK) disable iff (SRST)
        CRC_OUT_VALID && !CRC_OUT_ACK && !XFER_ABORT |=> CRC_OUT_VALID && $stable(CRC_OUT_DATA);
    endproperty
    a_offer_hold: assert property (p_offer_hold) else $error("crc offer changed");
endmodule
`default_nettype wire

// file: hw/dcc_pkg.sv
// constants for the channel crc-32 unit
// assumes an apb slave with 32-bit data and byte offsets as printed
package dcc_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0]  ADDR_CRC_VALUE   = 8'h24;
    localparam logic [7:0]  ADDR_OUT_STATUS  = 8'h28;
    localparam logic [7:0]  ADDR_TEST_SLOT   = 8'h2c;
    localparam logic [7:0]  ADDR_CONTROL     = 8'h20;
    localparam logic [31:0] CRC_VALUE_RESET  = 32'h00000000;
    localparam logic [31:0] CRC_POLY         = 32'h04c11db7;
    localparam logic [31:0] ALL_ONES         = 32'hffffffff;
    localparam logic [31:0] ZERO_WORD        = 32'h00000000;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int          STAT_DONE_BIT    = 2;
    localparam int          CTRL_CALC_BIT    = 0;
    localparam int          CTRL_POST_BIT    = 1;
    localparam int          BYTE_BITS        = 8;
endpackage

// file: testbench/dcc_dp_model.sv
// behavioural model of the channel datapath that feeds the crc unit
// assumes one clock shared with the unit and the transfer order start, bytes, done or abort
`timescale 1ns/1ps
`default_nettype none
module dcc_dp_model (
    input  wire logic       clk,
    input  wire logic       out_valid,
    output logic            start,
    output logic            byte_valid,
    output logic      [7:0] byte_val,
    output logic            done,
    output logic            abort,
    output logic            ack
);
    int unsigned ack_delay = 0;
    int unsigned wait_cnt  = 0;
    initial begin
        {start, byte_valid, done, abort, ack} = 5'h00;
        byte_val = 8'h00;
    end
    // raise ack ack_delay+1 cycles after the crc offer appears; slow answers stretch the offer
    always @(posedge clk) begin
        if (out_valid && !ack) begin
            if (wait_cnt >= ack_delay) ack <= 1'b1;
            wait_cnt <= wait_cnt + 1;
        end else begin
            ack      <= 1'b0;
            wait_cnt <= 0;
        end
    end
    // one transaction; the byte lane shows the inverse once released so stale data never matches
    task automatic xfer(input logic [7:0] d [8], input int n, input bit stop, input int dly);
        ack_delay = dly;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < n; i++) begin
            byte_valid <= 1'b1;
            byte_val   <= d[i];
            @(posedge clk);
        end
        byte_valid <= 1'b0;
        byte_val   <= ~byte_val;
        if (stop) abort <= 1'b1;
        else done <= 1'b1;
        @(posedge clk);
        {abort, done} <= 2'b00;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: testbench/dma_channel_crc32_unit_tb.sv
// self-checking bench for the channel crc-32 unit: apb master, scoreboard, datapath partner
// assumes dcc_pkg, dcc_crc_unit and dcc_dp_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module dma_channel_crc32_unit_tb;
    logic        CLOCK = 1'b0, SRST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, CRC_OUT_DATA, st, r;
    logic        PREADY, PSLVERR, XFER_START, XFER_BYTE_VALID, XFER_DONE, XFER_ABORT;
    logic        CRC_OUT_VALID, CRC_OUT_ACK, vld_q = 1'b0;
    logic [7:0]  XFER_BYTE, bytes [8];
    logic [1:0]  ctl = 2'b00;
    logic [32:0] exp_q [$];
    logic [31:0] out_q [$];
    int          fails = 0, checks_done = 0;
    dcc_crc_unit uut (.CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .XFER_START(XFER_START), .XFER_BYTE_VALID(XFER_BYTE_VALID),
        .XFER_BYTE(XFER_BYTE), .XFER_DONE(XFER_DONE), .XFER_ABORT(XFER_ABORT),
        .CRC_OUT_VALID(CRC_OUT_VALID), .CRC_OUT_DATA(CRC_OUT_DATA), .CRC_OUT_ACK(CRC_OUT_ACK));
    dcc_dp_model dp (.clk(CLOCK), .out_valid(CRC_OUT_VALID), .start(XFER_START),
        .byte_valid(XFER_BYTE_VALID), .byte_val(XFER_BYTE), .done(XFER_DONE),
        .abort(XFER_ABORT), .ack(CRC_OUT_ACK));
    initial forever #2.5 CLOCK = ~CLOCK;
    // ************************************************************
    // reference model and scoreboard
    // ************************************************************
    // msb-first shift register fed lsb first; the read view reverses and inverts it
    function automatic logic [31:0] step(input logic [31:0] s, input logic [7:0] b);
        for (int i = 0; i < 8; i++) s = {s[30:0], 1'b0} ^ ((s[31] ^ b[i]) ? dcc_pkg::CRC_POLY : 32'h0);
        return s;
    endfunction
    function automatic logic [31:0] rv(input logic [31:0] s);
        logic [31:0] o;
        for (int i = 0; i < 32; i++) o[i] = s[31 - i];
        return o;
    endfunction
    task automatic err(input string m);
        fails++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    // every apb answer and every new crc offer takes the oldest note of its queue
    always @(posedge CLOCK) begin
        if (PREADY === 1'b1) begin
            checks_done++;
            if (exp_q.size() == 0 || {PSLVERR, PRDATA} !== exp_q[0]) err("apb answer differs");
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
        if (CRC_OUT_VALID === 1'b1 && vld_q !== 1'b1) begin
            checks_done++;
            if (out_q.size() == 0 || CRC_OUT_DATA !== out_q[0]) err("crc output differs");
            if (out_q.size() != 0) void'(out_q.pop_front());
        end
        vld_q <= CRC_OUT_VALID;
    end
    // ************************************************************
    // drivers
    // ************************************************************
    // request held until pready is sampled high, released after that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int k;
        exp_q.push_back(e);
        PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        k = 0;
        do begin @(posedge CLOCK); k++; end while (PREADY !== 1'b1 && k < 20);
        if (PREADY !== 1'b1) begin err("no pready"); stop_test(); end
        PSEL <= 1'b0; PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0, {1'b0, e}); endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d, 33'h0); endtask
    // one transaction of n random bytes, then the done flag is read back
    task automatic run(input int n, input bit ab, input int dly);
        int k;
        for (int i = 0; i < n; i++) bytes[i] = 8'($urandom());
        for (int i = 0; i < n; i++) if (ctl[0]) st = step(st, bytes[i]);
        if (!ab && ctl[1]) out_q.push_back(~rv(st));
        dp.xfer(bytes, n, ab, dly);
        k = 0;
        while ((out_q.size() != 0 || CRC_OUT_VALID !== 1'b0) && k < 40) begin @(posedge CLOCK); k++; end
        if (k == 40) begin err("crc offer hangs"); stop_test(); end
        rd(dcc_pkg::ADDR_OUT_STATUS, (!ab && ctl[1]) ? 32'h4 : 32'h0);
        rd(dcc_pkg::ADDR_CRC_VALUE, ~rv(st));
        $display("transfer of %0d bytes ends", n);
    endtask
    task automatic stop_test();
        if (exp_q.size() + out_q.size() != 0) fails++;
        $display("comparisons %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'hc256));
        repeat (8) @(posedge CLOCK);
        SRST <= 1'b0;
        @(posedge CLOCK);
        st = dcc_pkg::CRC_VALUE_RESET;
        rd(dcc_pkg::ADDR_CRC_VALUE, ~rv(st));
        rd(dcc_pkg::ADDR_OUT_STATUS, 32'h0);
        rd(dcc_pkg::ADDR_TEST_SLOT, 32'h0);
        rd(dcc_pkg::ADDR_CONTROL, 32'h0);
        apb(1'b0, 8'h30, 32'h0, {1'b1, 32'h0});
        $display("reset values checked");
        wr(dcc_pkg::ADDR_CONTROL, 32'h3); ctl = 2'b11;
        wr(dcc_pkg::ADDR_CRC_VALUE, dcc_pkg::ALL_ONES); st = dcc_pkg::ALL_ONES;
        run(4, 1'b0, 0);
        run(3, 1'b0, 3);
        run(2, 1'b1, 0);
        r = ~rv(st);
        wr(dcc_pkg::ADDR_CRC_VALUE, ~rv(r));
        rd(dcc_pkg::ADDR_CRC_VALUE, r);
        st = $urandom();
        wr(dcc_pkg::ADDR_CRC_VALUE, st);
        rd(dcc_pkg::ADDR_CRC_VALUE, ~rv(st));
        $display("save and restore checked");
        wr(dcc_pkg::ADDR_CONTROL, 32'h2); ctl = 2'b10;
        run(4, 1'b0, 1);
        wr(dcc_pkg::ADDR_CONTROL, 32'h0); ctl = 2'b00;
        run(1, 1'b0, 0);
        wr(dcc_pkg::ADDR_OUT_STATUS, dcc_pkg::ALL_ONES);
        wr(dcc_pkg::ADDR_TEST_SLOT, dcc_pkg::ALL_ONES);
        rd(dcc_pkg::ADDR_OUT_STATUS, 32'h0);
        rd(dcc_pkg::ADDR_TEST_SLOT, 32'h0);
        $display("read-only slots checked");
        stop_test();
    end
endmodule
`default_nettype wire
